/* File: dcb_top.sv */
// Control bit decoder with phase accumulator core for the waveform generator
`timescale 1ns/100ps
module dcb_top
  import dcb_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic FSEL_PIN_I,
  input wire logic PSEL_PIN_I,
  input wire logic RESET_PIN_I,
  input wire logic SLEEP_PIN_I,
  input wire logic COMP_I,
  output logic [31:0] RDATA_O,
  output logic [DAC_W-1:0] DAC_DATA_O,
  output logic DAC_PDN_O,
  output logic SIGN_O,
  output logic SIGN_OE_O
);

  logic [CW_W-1:0] ctrl_r;
  logic [ACC_W-1:0] freq_a_r;
  logic [ACC_W-1:0] freq_b_r;
  logic [PH_W-1:0] phase_offset_reg_a;
  logic [PH_W-1:0] phase_offset_reg_b;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [DAC_W-1:0] dac_r;
  logic [DAC_W-1:0] dac_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic pdn_r;
  logic sign_r;
  logic sign_oe_r;

  // Pin or software bit, picked by the control source
  function automatic logic pick_src
  (
    input logic use_pin,
    input logic pin_val,
    input logic sw_val
  );
    return use_pin ? pin_val : sw_val;
  endfunction

  // Strobe qualified by one register address
  function automatic logic addr_hit
  (
    input logic strobe,
    input logic [2:0] addr,
    input logic [2:0] target
  );
    return strobe && (addr == target);
  endfunction

  // Offset binary code from the top phase bits; low bits are dropped, not rounded
  function automatic logic [DAC_W-1:0] dac_code
  (
    input logic [PH_W-1:0] phase
  );
    return {~phase[PH_W-1], phase[PH_W-2 -: DAC_W-1]};
  endfunction

  // Register decode
  wire wr_ctrl = addr_hit(WR_I, ADDR_I, ADDR_CTRL);
  wire wr_fa = addr_hit(WR_I, ADDR_I, ADDR_FREQ_A);
  wire wr_fb = addr_hit(WR_I, ADDR_I, ADDR_FREQ_B);
  wire wr_pa = addr_hit(WR_I, ADDR_I, ADDR_PH_A);
  wire wr_pb = addr_hit(WR_I, ADDR_I, ADDR_PH_B);

  // Source selection between pins and software bits
  wire control_source_bit = ctrl_r[BIT_SRC];
  wire fsel_eff = pick_src(control_source_bit, FSEL_PIN_I, ctrl_r[BIT_FSEL]);
  wire psel_eff = pick_src(control_source_bit, PSEL_PIN_I, ctrl_r[BIT_PSEL]);
  wire rst_eff = pick_src(control_source_bit, RESET_PIN_I, ctrl_r[BIT_RST]);
  // Converter powerdown: pin when source is pins, else software bit
  wire converter_powerdown_bit = ctrl_r[BIT_PDN];
  wire pdn_eff = pick_src(control_source_bit, SLEEP_PIN_I, converter_powerdown_bit);
  wire clock_gate_bit = ctrl_r[BIT_CLKG];
  wire sign_output_enable = ctrl_r[BIT_OPEN];
  wire sign_output_source = ctrl_r[BIT_SGNSRC];

  wire [ACC_W-1:0] step = fsel_eff ? freq_b_r : freq_a_r;
  wire [PH_W-1:0] poff = psel_eff ? phase_offset_reg_b : phase_offset_reg_a;
  wire [PH_W-1:0] phase_sum = acc_r[ACC_W-1 -: PH_W] + poff;
  wire sign_src_val = sign_output_source ? COMP_I : dac_r[DAC_W-1];
  wire sign_nxt = sign_output_enable & sign_src_val;

  // Read fields widened to the bus word
  wire [31:0] rd_ctrl = {16'h0000, ctrl_r};
  wire [31:0] rd_freq_a = {4'h0, freq_a_r};
  wire [31:0] rd_freq_b = {4'h0, freq_b_r};
  wire [31:0] rd_ph_a = {20'h00000, phase_offset_reg_a};
  wire [31:0] rd_ph_b = {20'h00000, phase_offset_reg_b};
  wire [31:0] rd_stat = {27'h0000000, pdn_eff, rst_eff, clock_gate_bit, psel_eff, fsel_eff};
  wire [31:0] rd_phase = {4'h0, acc_r};

  // Accumulator: cleared by reset, held by clock gate
  always_comb
  begin
    acc_nxt = acc_r;
    dac_nxt = dac_r;
    if (rst_eff)
    begin
      acc_nxt = ACC_ZERO;
      dac_nxt = DAC_MID;
    end
    else if (!clock_gate_bit)
    begin
      acc_nxt = acc_r + step;
      dac_nxt = dac_code(phase_sum);
    end
    else
    begin
      acc_nxt = acc_r;
      dac_nxt = dac_r;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = RD_ZERO;
    unique case (ADDR_I)
      ADDR_CTRL: rdata_nxt = rd_ctrl;
      ADDR_FREQ_A: rdata_nxt = rd_freq_a;
      ADDR_FREQ_B: rdata_nxt = rd_freq_b;
      ADDR_PH_A: rdata_nxt = rd_ph_a;
      ADDR_PH_B: rdata_nxt = rd_ph_b;
      ADDR_STAT: rdata_nxt = rd_stat;
      ADDR_PHASE: rdata_nxt = rd_phase;
      default: rdata_nxt = RD_ZERO;
    endcase
  end

  // Control word
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ctrl_r <= CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= WDATA_I[CW_W-1:0];
    end
  end

  // Frequency word A; upper bus bits are dropped
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      freq_a_r <= ACC_ZERO;
    end
    else if (wr_fa)
    begin
      freq_a_r <= WDATA_I[ACC_W-1:0];
    end
  end

  // Frequency word B
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      freq_b_r <= ACC_ZERO;
    end
    else if (wr_fb)
    begin
      freq_b_r <= WDATA_I[ACC_W-1:0];
    end
  end

  // Phase offset A
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      phase_offset_reg_a <= PH_ZERO;
    end
    else if (wr_pa)
    begin
      phase_offset_reg_a <= WDATA_I[PH_W-1:0];
    end
  end

  // Phase offset B
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      phase_offset_reg_b <= PH_ZERO;
    end
    else if (wr_pb)
    begin
      phase_offset_reg_b <= WDATA_I[PH_W-1:0];
    end
  end

  // Phase accumulator; wraps at full scale on purpose
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      acc_r <= ACC_ZERO;
    end
    else
    begin
      acc_r <= acc_nxt;
    end
  end

  // Converter code resets to midscale, not zero
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      dac_r <= DAC_MID;
    end
    else
    begin
      dac_r <= dac_nxt;
    end
  end

  // Read data returns to zero so stale words never linger
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rdata_r <= RD_ZERO;
    end
    else
    begin
      rdata_r <= RD_I ? rdata_nxt : RD_ZERO;
    end
  end

  // Powerdown follows its source one cycle late
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pdn_r <= 1'b0;
    end
    else
    begin
      pdn_r <= pdn_eff;
    end
  end

  // Sign pin enable
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sign_oe_r <= 1'b0;
    end
    else
    begin
      sign_oe_r <= sign_output_enable;
    end
  end

  // Sign data forced low while disabled, so no stray level leaks out
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sign_r <= 1'b0;
    end
    else
    begin
      sign_r <= sign_nxt;
    end
  end

  assign RDATA_O = rdata_r;
  assign DAC_DATA_O = dac_r;
  assign DAC_PDN_O = pdn_r;
  assign SIGN_O = sign_r;
  assign SIGN_OE_O = sign_oe_r;

endmodule

/* File: dcb_pkg.sv */
// Package with control word layout and constants for the control bit decoder
package dcb_pkg;
  localparam int CW_W = 16;
  localparam int PH_W = 12;
  localparam int ACC_W = 28;
  localparam int DAC_W = 10;
  // Control word bit positions
  localparam int BIT_FSEL = 11;
  localparam int BIT_PSEL = 10;
  localparam int BIT_SRC = 9;
  localparam int BIT_RST = 8;
  localparam int BIT_CLKG = 7;
  localparam int BIT_PDN = 6;
  localparam int BIT_OPEN = 5;
  localparam int BIT_SGNSRC = 4;
  // Register map of the plain register port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_FREQ_A = 3'h1;
  localparam logic [2:0] ADDR_FREQ_B = 3'h2;
  localparam logic [2:0] ADDR_PH_A = 3'h3;
  localparam logic [2:0] ADDR_PH_B = 3'h4;
  localparam logic [2:0] ADDR_STAT = 3'h5;
  localparam logic [2:0] ADDR_PHASE = 3'h6;
  localparam logic [CW_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_ZERO = 28'h0000000;
  localparam logic [PH_W-1:0] PH_ZERO = 12'h000;
  localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

/* File: dcb_top_asserts.sv */
// Port checker for the control bit decoder
`timescale 1ns/100ps
module dcb_top_asserts
  import dcb_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic FSEL_PIN_I,
  input wire logic PSEL_PIN_I,
  input wire logic RESET_PIN_I,
  input wire logic SLEEP_PIN_I,
  input wire logic COMP_I,
  input wire logic DAC_PDN_O,
  input wire logic SIGN_O,
  input wire logic SIGN_OE_O,
  input wire logic [2:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [DAC_W-1:0] DAC_DATA_O
);
  logic [CW_W-1:0] c_r;
  logic src, rst, pdn;
  logic [4:0] st;
  // Shadow of the control word, since the design's copy is hidden
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    if (!RESETN_I)
      c_r <= CTRL_RST;
    else if (WR_I && ADDR_I == ADDR_CTRL)
      c_r <= WDATA_I[CW_W-1:0];
  assign src = c_r[BIT_SRC];
  assign rst = src ? RESET_PIN_I : c_r[BIT_RST];
  assign pdn = src ? SLEEP_PIN_I : c_r[BIT_PDN];
  assign st = {pdn, rst, c_r[BIT_CLKG], src ? PSEL_PIN_I : c_r[BIT_PSEL],
    src ? FSEL_PIN_I : c_r[BIT_FSEL]};
  default clocking dcb_ck @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == RD_ZERO) else $error("stale read");
  AST_UNMAP: assert property (RD_I && ADDR_I == 3'h7 |=> RDATA_O == RD_ZERO)
    else $error("unmapped read");
  AST_CTRL: assert property (RD_I && ADDR_I == ADDR_CTRL |=> RDATA_O == {16'h0000, $past(c_r)})
    else $error("control readback");
  AST_STAT: assert property (RD_I && ADDR_I == ADDR_STAT |=> RDATA_O == {27'h0, $past(st)})
    else $error("status");
  AST_PDN: assert property (DAC_PDN_O == $past(pdn)) else $error("powerdown");
  AST_MID: assert property (rst |=> DAC_DATA_O == DAC_MID) else $error("midscale");
  // The gate holds the code under either control source; this check covers software control only
  AST_GATE: assert property ((c_r[BIT_CLKG] && !rst && !src && !WR_I) [*3] |=> $stable(DAC_DATA_O))
    else $error("gate");
  AST_SIGN: assert property (SIGN_OE_O == $past(c_r[BIT_OPEN]) && (SIGN_OE_O ?
    SIGN_O == ($past(c_r[BIT_SGNSRC]) ? $past(COMP_I) : $past(DAC_DATA_O[DAC_W-1])) : !SIGN_O))
    else $error("sign pin");
endmodule
bind dcb_top dcb_top_asserts u_chk (.*);

/* File: tb_dcb_top.sv */
// Self-checking bench for the control bit decoder
`timescale 1ns/100ps
module tb_dcb_top
  import dcb_pkg::*;
;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, fp = 0, pp = 0, rp = 0, sp = 0, cp = 0;
  logic pdn, sg, oe;
  logic [2:0] ad = 3'h0;
  logic [31:0] wd = 32'h0, rdat, c, f, v, q, e;
  logic [DAC_W-1:0] dac;
  int error_cnt = 0, checked = 0;
  dcb_top dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(ad), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .FSEL_PIN_I(fp), .PSEL_PIN_I(pp), .RESET_PIN_I(rp), .SLEEP_PIN_I(sp),
    .COMP_I(cp), .RDATA_O(rdat), .DAC_DATA_O(dac), .DAC_PDN_O(pdn), .SIGN_O(sg),
    .SIGN_OE_O(oe));
  initial forever #5 clk = ~clk;
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk) {wr, ad, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  task bus_rd(input logic [2:0] a, output logic [31:0] r);
    @(posedge clk) {rd, ad} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) r = rdat;
  endtask
  function automatic logic [31:0] st(input logic [31:0] w);
    return {27'h0, w[9] ? sp : w[6], w[9] ? rp : w[8], w[7], w[9] ? pp : w[10], w[9] ? fp : w[11]};
  endfunction
  task wrap_up;
    $display("mismatches %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    v = $urandom(32'hE7D5);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      c = $urandom & 32'hFFFF;
      {fp, pp, rp, sp, cp} <= 5'($urandom);
      bus_wr(ADDR_CTRL, c);
      bus_rd(ADDR_STAT, v);
      e = st(c);
      cmp(v, e);
      cmp(32'(pdn), 32'(e[4]));
      cmp(32'({oe, c[4] ? sg : 1'b0}), 32'({c[5], c[5] & c[4] & cp}));
    end
    bus_rd(3'h7, v);
    cmp(v, RD_ZERO);
    {fp, pp, rp, sp} <= 4'h0;
    bus_wr(ADDR_CTRL, 32'h100);
    bus_rd(ADDR_PHASE, v);
    cmp(v, RD_ZERO);
    cmp(32'(dac), 32'(DAC_MID));
    // Both frequency words are still zero, so the accumulator stays at zero
    bus_wr(ADDR_CTRL, 32'h80);
    f = $urandom & 32'hFFF;
    q = $urandom & 32'hFFF;
    bus_wr(ADDR_PH_A, f);
    bus_wr(ADDR_PH_B, q);
    for (int p = 0; p < 2; p++)
    begin
      bus_wr(ADDR_CTRL, p << 10);
      bus_rd(ADDR_STAT, v);
      e = p ? q : f;
      cmp(32'(dac), 32'({~e[11], e[10:2]}));
      bus_wr(ADDR_CTRL, 32'h80 | (1 - p) << 10);
      bus_rd(ADDR_STAT, v);
      cmp(32'(dac), 32'({~e[11], e[10:2]}));
    end
    for (int i = 0; i < 8; i++)
    begin
      f = $urandom & 32'hFFFFFFF;
      bus_wr(ADDR_FREQ_A, f);
      bus_wr(ADDR_CTRL, i % 2 << 7);
      bus_rd(ADDR_PHASE, v);
      bus_rd(ADDR_PHASE, q);
      cmp(q - v & 32'hFFFFFFF, i % 2 ? 0 : 3 * f & 32'hFFFFFFF);
    end
    wrap_up();
  end
endmodule
